// file: src/dead_band_pkg.sv
// Constants shared by the dead-band generator and its counter.
// Assumes a 32-bit classic Wishbone register port with byte addresses.
package dead_band_pkg;

    localparam int          DB_W            = 6;
    localparam int          ADR_W           = 4;

    // Register byte offsets
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_RISE       = 4'h4;
    localparam logic [3:0]  ADDR_FALL       = 4'h8;
    localparam logic [3:0]  ADDR_STATUS     = 4'hc;

    // Control register fields
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_MODE_LSB   = 1;
    localparam int          CTRL_LD_BIT     = 3;

    // Status register fields
    localparam int          STAT_RISE_LSB   = 0;
    localparam int          STAT_FALL_LSB   = 8;
    localparam int          STAT_DIR_BIT    = 16;
    localparam int          STAT_HOLD_BIT   = 17;
    localparam int          STAT_OUT_LSB    = 20;

    // Reset values
    localparam logic [DB_W-1:0] DB_RESET    = 6'h00;
    localparam logic [31:0]     DATA_ZERO   = 32'h0000_0000;

    // Bit 0 of the mode doubles as the full-bridge direction (1 = reverse)
    typedef enum logic [1:0] {
        MODE_STEER  = 2'h0,
        MODE_HALF   = 2'h1,
        MODE_FWD    = 2'h2,
        MODE_REV    = 2'h3
    } bridge_mode_e;

endpackage : dead_band_pkg

// file: src/dead_band_counter.sv
// One 6-bit dead-band counter: counts generator clocks up from zero.
// Assumes start and run are synchronous to mclk; done is combinational.
`timescale 1ns/10ps
module dead_band_counter
    import dead_band_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            start,
    input  wire logic            run,
    input  wire logic [DB_W-1:0] limit,
    output logic                 done
);

    typedef struct packed {
        logic            busy;
        logic [DB_W-1:0] cnt;
    } cnt_state_s;

    cnt_state_s s_q;
    cnt_state_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (start)
        begin
            // A fresh edge discards any unfinished interval
            s_d.busy = 1'b1;
            s_d.cnt  = DB_RESET;
        end
        else if (!run)
        begin
            // Level ended early: interval abandoned, no pulse
            s_d.busy = 1'b0;
        end
        else if (s_q.busy && (s_q.cnt < limit))
        begin
            s_d.cnt = s_q.cnt + 6'h01;
        end
    end

    // Compare with >= so a smaller limit loaded mid-count still ends the interval; the count holds at the limit
    assign done = s_q.busy && run && (s_q.cnt >= limit);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : dead_band_counter

// file: src/dead_band_bridge.sv
// Dead-band insertion for a complementary waveform generator, with a
// classic Wishbone slave for control, dead-band values and status.
// Assumes src_in is synchronous to mclk; generator clock equals mclk.
//
// Summary of operation
// - Two independent 6-bit dead-band counters time the non-overlap intervals.
// - First counter: after rising edge in half bridge, reverse band in full.
// - Second counter: after falling edge in half bridge, forward band in full.
// - Interval counts clocks up from zero until it equals the register value.
// - Dead band is inserted only in half-bridge and full-bridge modes.
// - Half bridge: inverted output rises a dead band after normal output falls.
// - Full bridge: dead band only inserted on a direction change or the first rising edge after entering the mode.
// - Direction bit may be changed while the generator runs.
// - After direction change, output_a and output_c switch at first rising edge.
// - Newly modulated output stays off for the dead-band count after change.
// - Rising value delays output_a in half bridge, output_b in full bridge.
// - Rising value double-buffered; loads at once while generator disabled.
// - While enabled, load request moves buffers into use at next falling edge.
// - Input level too short for the count gives no pulse on that output.
// - Falling value delays output_b half, output_d full; same buffering.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
module dead_band_bridge
    import dead_band_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             src_in,
    output logic                  output_a,
    output logic                  output_b,
    output logic                  output_c,
    output logic                  output_d
);

    typedef struct packed {
        logic            en;
        bridge_mode_e    mode;
        logic            ld;
        logic [DB_W-1:0] rise_buf;
        logic [DB_W-1:0] fall_buf;
        logic [DB_W-1:0] rise_act;
        logic [DB_W-1:0] fall_act;
        logic            src_q;
        logic            dir_valid;
        logic            dir_rev;
        logic            hold;
        logic            out_a;
        logic            out_b;
        logic            out_c;
        logic            out_d;
        logic            ack;
        logic [31:0]     dat;
    } bridge_state_s;

    bridge_state_s s_q;
    bridge_state_s s_d;

    logic rise_start;
    logic rise_run;
    logic rise_done;
    logic fall_start;
    logic fall_run;
    logic fall_done;
    logic rise_edge;
    logic fall_edge;
    logic is_half;
    logic is_full;
    logic new_rev;
    logic dir_change;

    // All writable fields sit in byte lane 0, so only that lane gates a write
    function automatic logic lane0_write(input logic [3:0] sel, input logic we);
        lane0_write = we && sel[0];
    endfunction : lane0_write

    assign rise_edge  = src_in && !s_q.src_q;
    assign fall_edge  = !src_in && s_q.src_q;
    assign is_half    = s_q.en && (s_q.mode == MODE_HALF);
    assign is_full    = s_q.en && s_q.mode[1];
    assign new_rev    = s_q.mode[0];
    assign dir_change = is_full && rise_edge
                        && (!s_q.dir_valid || (s_q.dir_rev != new_rev));

    // Counter 1: rising edge in half bridge, reverse band in full bridge
    assign rise_start = is_half ? rise_edge : (dir_change && new_rev);
    assign rise_run   = src_in;
    // Counter 2: falling edge in half bridge, forward band in full bridge
    assign fall_start = is_half ? fall_edge : (dir_change && !new_rev);
    assign fall_run   = is_half ? !src_in : src_in;

    dead_band_counter u_rise_cnt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (rise_start),
        .run   (rise_run),
        .limit (s_q.rise_act),
        .done  (rise_done)
    );

    dead_band_counter u_fall_cnt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (fall_start),
        .run   (fall_run),
        .limit (s_q.fall_act),
        .done  (fall_done)
    );

    always_comb
    begin
        logic        bus_req;
        logic        bus_wr;
        logic        mod_done;
        logic        mod_on;
        logic [31:0] rd;
        bus_req  = 1'b0;
        bus_wr   = 1'b0;
        mod_done = 1'b0;
        mod_on   = 1'b0;
        rd       = DATA_ZERO;
        s_d      = s_q;

        s_d.src_q = src_in;

        // Buffered values enter use at the falling input edge
        if (s_q.en && s_q.ld && fall_edge)
        begin
            s_d.rise_act = s_q.rise_buf;
            s_d.fall_act = s_q.fall_buf;
            s_d.ld       = 1'b0;
        end

        // A disabled generator drops a stale request; a write below still sets it
        if (!s_q.en)
        begin
            s_d.ld = 1'b0;
        end

        // Wishbone: answer one cycle after the request appears, then drop.
        // A write lands at the edge on which the master sees ack, so a request
        // withdrawn before ack leaves the registers untouched.
        bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
        bus_wr  = wb_cyc_i && wb_stb_i && s_q.ack && lane0_write(wb_sel_i, wb_we_i);
        s_d.ack = bus_req;

        if (bus_wr)
        begin
            case (wb_adr_i)
                ADDR_CTRL:
                begin
                    s_d.en   = wb_dat_i[CTRL_EN_BIT];
                    s_d.mode = bridge_mode_e'(wb_dat_i[CTRL_MODE_LSB +: 2]);
                    // Load request is write-one-to-set; a set beats the clear
                    if (wb_dat_i[CTRL_LD_BIT])
                    begin
                        s_d.ld = 1'b1;
                    end
                end
                ADDR_RISE:
                begin
                    s_d.rise_buf = wb_dat_i[DB_W-1:0];
                    if (!s_q.en)
                    begin
                        s_d.rise_act = wb_dat_i[DB_W-1:0];
                    end
                end
                ADDR_FALL:
                begin
                    s_d.fall_buf = wb_dat_i[DB_W-1:0];
                    if (!s_q.en)
                    begin
                        s_d.fall_act = wb_dat_i[DB_W-1:0];
                    end
                end
                default:
                begin
                    s_d.dat = s_q.dat;
                end
            endcase
        end

        case (wb_adr_i)
            ADDR_CTRL:
            begin
                rd[CTRL_EN_BIT]             = s_q.en;
                rd[CTRL_MODE_LSB +: 2]      = s_q.mode;
                rd[CTRL_LD_BIT]             = s_q.ld;
            end
            ADDR_RISE:
            begin
                rd[DB_W-1:0]                = s_q.rise_buf;
            end
            ADDR_FALL:
            begin
                rd[DB_W-1:0]                = s_q.fall_buf;
            end
            ADDR_STATUS:
            begin
                rd[STAT_RISE_LSB +: DB_W]   = s_q.rise_act;
                rd[STAT_FALL_LSB +: DB_W]   = s_q.fall_act;
                rd[STAT_DIR_BIT]            = s_q.dir_rev;
                rd[STAT_HOLD_BIT]           = s_q.hold;
                rd[STAT_OUT_LSB +: 4]       = {s_q.out_d, s_q.out_c, s_q.out_b, s_q.out_a};
            end
            default:
            begin
                rd = DATA_ZERO;
            end
        endcase
        s_d.dat = (bus_req && !wb_we_i) ? rd : DATA_ZERO;

        // Output generation
        if (!s_q.en)
        begin
            s_d.out_a     = 1'b0;
            s_d.out_b     = 1'b0;
            s_d.out_c     = 1'b0;
            s_d.out_d     = 1'b0;
            s_d.hold      = 1'b0;
            s_d.dir_valid = 1'b0;
        end
        else if (is_half)
        begin
            // Each side only rises once its counter finishes in its own level
            s_d.out_a     = src_in && rise_done;
            s_d.out_b     = !src_in && fall_done;
            s_d.out_c     = s_d.out_a;
            s_d.out_d     = s_d.out_b;
            s_d.hold      = 1'b0;
            s_d.dir_valid = 1'b0;
        end
        else if (is_full)
        begin
            if (dir_change)
            begin
                // Static pair flips now; the new modulated leg waits out the band
                s_d.dir_valid = 1'b1;
                s_d.dir_rev   = new_rev;
                s_d.out_a     = !new_rev;
                s_d.out_c     = new_rev;
                s_d.out_b     = 1'b0;
                s_d.out_d     = 1'b0;
                s_d.hold      = 1'b1;
            end
            else if (s_q.dir_valid)
            begin
                mod_done = s_q.dir_rev ? rise_done : fall_done;
                mod_on   = src_in && (!s_q.hold || mod_done);
                if (s_q.hold && (mod_done || !src_in))
                begin
                    // A short first pulse is simply dropped
                    s_d.hold = 1'b0;
                end
                s_d.out_b = s_q.dir_rev && mod_on;
                s_d.out_d = !s_q.dir_rev && mod_on;
            end
            else
            begin
                // Waiting for the first rising edge after entering the mode
                s_d.out_a = 1'b0;
                s_d.out_b = 1'b0;
                s_d.out_c = 1'b0;
                s_d.out_d = 1'b0;
            end
        end
        else
        begin
            // Steering: no complementary pair, so no dead band is inserted
            s_d.out_a     = src_in;
            s_d.out_b     = 1'b0;
            s_d.out_c     = 1'b0;
            s_d.out_d     = 1'b0;
            s_d.hold      = 1'b0;
            s_d.dir_valid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.mode     <= MODE_STEER;
            s_q.rise_buf <= DB_RESET;
            s_q.fall_buf <= DB_RESET;
            s_q.rise_act <= DB_RESET;
            s_q.fall_act <= DB_RESET;
            s_q.dat      <= DATA_ZERO;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign output_a = s_q.out_a;
    assign output_b = s_q.out_b;
    assign output_c = s_q.out_c;
    assign output_d = s_q.out_d;

endmodule : dead_band_bridge

// file: tb/pwm_pulse_source.sv
// Source model: one high then one low period of src_in per go request.
// Assumes go and lengths change after the rising edge; lengths are 1 or more.
`timescale 1ns/10ps
module pwm_pulse_source
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] hi_len,
    input  wire logic [7:0] lo_len,
    output logic            src_in,
    output logic            busy
);
    logic [7:0] cnt_q;
    logic       low_q;
    assign busy = cnt_q != 8'h00;
    // Idle level is low, so a pending fall band always gets to finish
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {cnt_q, low_q, src_in} <= {8'h00, 2'b00};
        else if (go && !busy)
            {cnt_q, low_q, src_in} <= {hi_len, 2'b01};
        else if (cnt_q == 8'h01 && !low_q)
            {cnt_q, low_q, src_in} <= {lo_len, 2'b10};
        else if (busy)
            cnt_q <= cnt_q - 8'h01;
endmodule : pwm_pulse_source

// file: tb/dead_band_bridge_sva.sv
// Port checker for the dead-band bridge.
// Assumes the bind below; follows control writes by watching the bus.
`timescale 1ns/10ps
module dead_band_bridge_sva
    import dead_band_pkg::*;
(
    input wire logic             mclk,
    input wire logic             rst_n,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             src_in,
    input wire logic             output_a,
    input wire logic             output_b,
    input wire logic             output_c,
    input wire logic             output_d
);
    logic [2:0] ctrl_q;
    logic [2:0] prev_q;
    wire        take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        half  = ctrl_q == 3'h3 && prev_q == 3'h3;
    wire        steer = ctrl_q == 3'h1 && prev_q == 3'h1;
    wire        off   = !ctrl_q[0] && !prev_q[0];
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {ctrl_q, prev_q} <= 6'h00;
        else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == ADDR_CTRL)
            {ctrl_q, prev_q} <= {wb_dat_i[2:0], ctrl_q};
        else
            prev_q <= ctrl_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence src_up;
        !src_in ##1 src_in;
    endsequence
    sequence src_down;
        src_in ##1 !src_in;
    endsequence
    ack_answer_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO)
        else $error("read data not zero outside ack");
    overlap_ab_a: assert property (!(output_a && output_b))
        else $error("output_a and output_b high together");
    overlap_cd_a: assert property (!(output_c && output_d))
        else $error("output_c and output_d high together");
    gen_off_a: assert property (off |-> !(output_a | output_b | output_c | output_d))
        else $error("output active while disabled");
    steer_follow_a: assert property (steer |-> output_a == $past(src_in))
        else $error("steer output not source delayed by one");
    half_pair_a: assert property (half |-> output_c == output_a && output_d == output_b)
        else $error("half bridge pair mismatch");
    rise_band_a: assert property (half ##0 src_up |=> !output_a)
        else $error("output_a rose without dead band");
    fall_band_a: assert property (half ##0 src_down |=> !output_b)
        else $error("output_b rose without dead band");
    rise_hold_a: assert property (half && $rose(output_a) |-> $past(src_in, 2))
        else $error("output_a pulse from short source level");
    fall_hold_a: assert property (half && $rose(output_b) |-> !$past(src_in, 2))
        else $error("output_b pulse from short source level");
    a_release_a: assert property (half ##0 src_down |-> ##[0:1] !output_a)
        else $error("output_a late to fall");
endmodule : dead_band_bridge_sva
bind dead_band_bridge dead_band_bridge_sva u_sva (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_in(src_in), .output_a(output_a), .output_b(output_b), .output_c(output_c),
    .output_d(output_d));

// file: tb/test_dead_band_bridge.sv
// Self-checking bench for the dead-band bridge.
// Assumes the pulse source model and the bound port checker.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module test_dead_band_bridge
    import dead_band_pkg::*;
;
    logic             mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic             go = 1'b0, wb_ack_o, src_in, busy, sa, sb, sd, ss;
    logic             output_a, output_b, output_c, output_d;
    logic [ADR_W-1:0] adr = 4'h0;
    logic [3:0]       sel = 4'h0;
    logic [31:0]      dat = DATA_ZERO, wb_dat_o, rd;
    logic [7:0]       hl = 8'h01, ll = 8'h01;
    int               n_errors = 0, samples_checked = 0, cyc_n = 0, t_r = 0, t_f = 0;
    int               d_a, db_f, db_r, dd_r, n_a = 0, c0, k, nr, nf, hi;
    int               seed = 32'hbaae_61b7;
    always #5 mclk = ~mclk;
    dead_band_bridge uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .src_in(src_in), .output_a(output_a), .output_b(output_b),
        .output_c(output_c), .output_d(output_d));
    pwm_pulse_source src (.mclk(mclk), .rst_n(rst_n), .go(go), .hi_len(hl),
        .lo_len(ll), .src_in(src_in), .busy(busy));
    // Edge-to-rise distances, in samples, seen at each rising clock edge
    always @(posedge mclk)
    begin
        cyc_n++;
        if (src_in && !ss) t_r = cyc_n;
        if (!src_in && ss) t_f = cyc_n;
        if (output_a && !sa) d_a = cyc_n - t_r;
        n_a += output_a && !sa;
        if (output_b && !sb) db_f = cyc_n - t_f;
        if (output_b && !sb) db_r = cyc_n - t_r;
        if (output_d && !sd) dd_r = cyc_n - t_r;
        {sa, sb, sd, ss} = {output_a, output_b, output_d, src_in};
    end
    function automatic int band(input int n);
        return n + 2;
    endfunction : band
    function automatic int pulses(input int n, input int h);
        return h >= n + 2;
    endfunction : pulses
    task finish_test(input int bad);
        n_errors += bad;
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'h1};
        do
        begin
            @(posedge mclk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) finish_test(1);
        rd = wb_dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge mclk);
    endtask : wb
    task automatic pulse(input int h, input int l);
        int i;
        i = 0;
        // Stale distances from an earlier pulse must not satisfy a check
        d_a = -1;
        db_f = -1;
        db_r = -1;
        dd_r = -1;
        {go, hl, ll} <= {1'b1, 8'(h), 8'(l)};
        @(posedge mclk);
        go <= 1'b0;
        do
        begin
            @(posedge mclk);
            i++;
        end while (busy !== 1'b0 && i < 400);
        if (i >= 400) finish_test(1);
        repeat (2) @(posedge mclk);
    endtask : pulse
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        wb(1'b1, ADDR_STATUS, 32'hffff_ffff);
        wb(1'b1, 4'h6, 32'hffff_ffff);
        for (k = 0; k < 5; k++)
        begin
            wb(1'b0, k == 4 ? 4'h6 : 4'(k * 4), DATA_ZERO);
            `CHK("reset or unmapped read", DATA_ZERO, rd)
        end
        wb(1'b1, ADDR_RISE, 32'h0000_0003);
        wb(1'b0, ADDR_STATUS, DATA_ZERO);
        `CHK("active rise", 6'h03, rd[5:0])
        wb(1'b1, ADDR_FALL, 32'h0000_0002);
        wb(1'b1, ADDR_CTRL, 32'h0000_0003);
        wb(1'b1, ADDR_RISE, 32'h0000_0005);
        wb(1'b1, ADDR_FALL, 32'h0000_0006);
        pulse(8, 12);
        `CHK("old rise band", band(3), d_a)
        wb(1'b0, ADDR_STATUS, DATA_ZERO);
        `CHK("unloaded values", 14'h0203, rd[13:0])
        wb(1'b1, ADDR_CTRL, 32'h0000_000b);
        pulse(8, 12);
        wb(1'b0, ADDR_CTRL, DATA_ZERO);
        `CHK("load request cleared", 4'h3, rd[3:0])
        wb(1'b0, ADDR_STATUS, DATA_ZERO);
        `CHK("loaded values", 14'h0605, rd[13:0])
        pulse(10, 12);
        `CHK("new rise band", band(5), d_a)
        `CHK("new fall band", band(6), db_f)
        wb(1'b1, ADDR_CTRL, 32'h0000_0001);
        pulse(6, 6);
        `CHK("steer delay", 1, d_a)
        wb(1'b1, ADDR_CTRL, DATA_ZERO);
        wb(1'b1, ADDR_RISE, 32'h0000_0004);
        wb(1'b1, ADDR_FALL, 32'h0000_0002);
        wb(1'b1, ADDR_CTRL, 32'h0000_0005);
        pulse(10, 8);
        `CHK("forward band", band(2), dd_r)
        `CHK("forward legs", 2'b10, {output_a, output_c})
        pulse(10, 8);
        `CHK("no band same direction", 1, dd_r)
        wb(1'b1, ADDR_CTRL, 32'h0000_0007);
        pulse(10, 8);
        `CHK("reverse band", band(4), db_r)
        `CHK("reverse legs", 2'b01, {output_a, output_c})
        wb(1'b0, ADDR_STATUS, DATA_ZERO);
        `CHK("reverse status", 8'h41, rd[23:16])
        for (k = 0; k < 8; k++)
        begin
            nr = k == 2 ? 63 : ($random(seed) & 7) + 1;
            nf = $random(seed) & 7;
            hi = k == 0 ? nr : k == 1 ? nr + 2 : k == 2 ? 65 : ($random(seed) & 15) + 1;
            if (hi == nr + 1) hi++;
            wb(1'b1, ADDR_CTRL, 32'h0000_0002);
            wb(1'b1, ADDR_RISE, 32'(nr));
            wb(1'b1, ADDR_FALL, 32'(nf));
            wb(1'b1, ADDR_CTRL, 32'h0000_0003);
            c0 = n_a;
            pulse(hi, 12);
            `CHK("pulse count", pulses(nr, hi), n_a - c0)
            if (hi >= nr + 2) `CHK("rise band", band(nr), d_a)
            `CHK("fall band", band(nf), db_f)
        end
        finish_test(0);
    end
endmodule : test_dead_band_bridge
